// ---- verilog/splc_pkg.sv ----
package splc_pkg;
  localparam int DATA_W = 16;
  localparam int PC_W = 23;
  localparam int STATUS_W = 8;
  // Lower bound guarding the special function register space
  localparam logic [15:0] UNDERFLOW_BOUND = 16'h0800;
  localparam logic [15:0] SP_RESET = 16'h0800;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam int LIMIT_LSB = 0;
  // Stacked high word: PC bits 22:16, bit 7 zero, top byte zero or status byte
  localparam int PCH_W = 7;
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  typedef enum logic [2:0] {
    SPLC_IDLE = 3'b001,
    SPLC_PUSH_HI = 3'b010,
    SPLC_POP_HI = 3'b100
  } splc_state_t;
endpackage : splc_pkg

// ---- verilog/splc_prio_enc.sv ----
module splc_prio_enc #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] req, // Requests, index 0 is lowest vector address
  output logic any, // Some request present
  output logic [W-1:0] idx // Winning index
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    // Lowest index (lowest address) wins
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule : splc_prio_enc

// ---- verilog/splc_stack_checker.sv ----
module splc_stack_checker
  import splc_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic rst_b, // Async reset, active low
  input wire logic pushReq, // Call push request
  input wire logic excPushReq, // Exception push request
  input wire logic popReq, // Pop request (two words)
  input wire logic [splc_pkg::PC_W-1:0] pcIn, // Program counter to stack
  input wire logic [splc_pkg::STATUS_W-1:0] statusLowByte, // Status low byte
  input wire logic ptrAddrValid, // Other pointer-based address formed
  input wire logic [splc_pkg::DATA_W-1:0] effectiveAddress, // That address
  input wire logic limitWrite, // Load limit register
  input wire logic [splc_pkg::DATA_W-1:0] limitData, // New limit value
  input wire logic spWrite, // Direct pointer write
  input wire logic [splc_pkg::DATA_W-1:0] spData, // Direct pointer value
  input wire logic [splc_pkg::DATA_W-1:0] memRdata, // Popped data word
  input wire logic [splc_pkg::NUM_SRC-1:0] trapReqs, // Other trap sources
  output logic [splc_pkg::DATA_W-1:0] stackPointerReg, // Pointer
  output logic [splc_pkg::DATA_W-1:0] stackLimitReg, // Limit
  output logic memWe, // Stack write strobe
  output logic memRe, // Stack read strobe
  output logic [splc_pkg::DATA_W-1:0] memAddr, // Stack access address
  output logic [splc_pkg::DATA_W-1:0] memWdata, // Stack write data
  output logic [splc_pkg::DATA_W-1:0] popData, // Word read by a pop
  output logic popValid, // Pop word valid
  output logic stackErrTrap, // Stack error trap, one cycle per failing check
  output logic trapValid, // Winning vector valid
  output logic [splc_pkg::SRC_W-1:0] trapIdx // Winning vector index
);
  import splc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State
  splc_state_t state_r;
  logic [DATA_W-1:0] sp_r;
  logic [DATA_W-1:0] lim_r;
  logic [DATA_W-1:0] hiWord_r;
  logic memWe_r;
  logic memRe_r;
  logic [DATA_W-1:0] memAddr_r;
  logic [DATA_W-1:0] memWdata_r;
  logic [DATA_W-1:0] popData_r;
  logic popValid_r;
  logic readPending_r;
  logic err_r;
  logic trapValid_r;
  logic [SRC_W-1:0] trapIdx_r;

  logic pushAct;
  logic popAct;
  logic [DATA_W-1:0] accAddr;
  logic spAccess;
  logic overflow;
  logic underflow;
  logic [DATA_W-1:0] lim_nxt;
  logic [NUM_SRC-1:0] allTraps;
  logic prioAny;
  logic [SRC_W-1:0] prioIdx;

  assign stackPointerReg = sp_r;
  assign stackLimitReg = lim_r;
  assign memWe = memWe_r;
  assign memRe = memRe_r;
  assign memAddr = memAddr_r;
  assign memWdata = memWdata_r;
  assign popData = popData_r;
  assign popValid = popValid_r;
  assign stackErrTrap = err_r;
  assign trapValid = trapValid_r;
  assign trapIdx = trapIdx_r;

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencing
  always_comb begin
    pushAct = 1'b0;
    popAct = 1'b0;
    accAddr = effectiveAddress;
    spAccess = ptrAddrValid;
    unique case (state_r)
      SPLC_IDLE: begin
        if (pushReq || excPushReq) begin
          pushAct = 1'b1;
        end else if (popReq) begin
          popAct = 1'b1;
        end
      end
      SPLC_PUSH_HI: pushAct = 1'b1;
      SPLC_POP_HI: popAct = 1'b1;
      default: ;
    endcase
    if (pushAct) begin
      accAddr = sp_r;
      spAccess = 1'b1;
    end else if (popAct) begin
      accAddr = DATA_W'(sp_r - WORD_STEP);
      spAccess = 1'b1;
    end
  end

  // Limit check on the push or pop address, else on the other pointer-based address
  assign overflow = spAccess && (accAddr > lim_r);
  assign underflow = spAccess && (accAddr < UNDERFLOW_BOUND);

  // Limit bit zero held at zero
  always_comb begin
    lim_nxt = limitData;
    lim_nxt[LIMIT_LSB] = 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SPLC_IDLE;
    end else begin
      unique case (state_r)
        SPLC_IDLE: begin
          if (pushReq || excPushReq) begin
            state_r <= SPLC_PUSH_HI;
          end else if (popReq) begin
            state_r <= SPLC_POP_HI;
          end
        end
        SPLC_PUSH_HI: state_r <= SPLC_IDLE;
        SPLC_POP_HI: state_r <= SPLC_IDLE;
        default: state_r <= SPLC_IDLE;
      endcase
    end
  end

  // High stacked word formed at push start
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hiWord_r <= '0;
    end else if (state_r == SPLC_IDLE && excPushReq) begin
      hiWord_r <= {statusLowByte, 1'b0, pcIn[PC_W-1:16]};
    end else if (state_r == SPLC_IDLE && pushReq) begin
      hiWord_r <= {STATUS_W'(0), 1'b0, pcIn[PC_W-1:16]};
    end
  end

  // Pointer: first free word, grows upward
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sp_r <= SP_RESET;
    end else if (pushAct) begin
      sp_r <= DATA_W'(sp_r + WORD_STEP);
    end else if (popAct) begin
      sp_r <= DATA_W'(sp_r - WORD_STEP);
    end else if (spWrite) begin
      sp_r <= {spData[DATA_W-1:1], 1'b0};
    end
  end

  // No functional reset value for the limit
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lim_r <= '0;
    end else if (limitWrite) begin
      lim_r <= lim_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      memWe_r <= 1'b0;
      memRe_r <= 1'b0;
      memAddr_r <= '0;
      memWdata_r <= '0;
    end else begin
      memWe_r <= pushAct;
      memRe_r <= popAct;
      memAddr_r <= (pushAct || popAct) ? accAddr : memAddr_r;
      if (pushAct) begin
        memWdata_r <= (state_r == SPLC_IDLE) ? pcIn[15:0] : hiWord_r;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      readPending_r <= 1'b0;
      popValid_r <= 1'b0;
      popData_r <= '0;
    end else begin
      readPending_r <= memRe_r;
      popValid_r <= readPending_r;
      if (readPending_r) begin
        popData_r <= memRdata;
      end
    end
  end

  // Error request, high one cycle after each failing check
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      err_r <= 1'b0;
    end else begin
      err_r <= overflow || underflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector arbitration, stack error in slot 2
  always_comb begin
    allTraps = trapReqs;
    allTraps[2] = trapReqs[2] | err_r;
  end

  splc_prio_enc #(
    .N(NUM_SRC),
    .W(SRC_W)
  ) uPrio (
    .req(allTraps),
    .any(prioAny),
    .idx(prioIdx)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trapValid_r <= 1'b0;
      trapIdx_r <= '0;
    end else begin
      trapValid_r <= prioAny;
      trapIdx_r <= prioIdx;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_PUSH_INC: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == SPLC_IDLE && pushReq && !popReq && !excPushReq)
    |=> sp_r == $past(sp_r) + WORD_STEP ##1 sp_r == $past(sp_r, 2) + 16'h0004)
    else $error("push did not advance pointer");
  AST_POP_DEC: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == SPLC_IDLE && popReq && !pushReq && !excPushReq)
    |=> memRe && memAddr == $past(sp_r) - WORD_STEP)
    else $error("pop did not predecrement");
  AST_LIM_LSB: assert property (@(posedge clock) disable iff (!rst_b)
    !stackLimitReg[0])
    else $error("limit bit zero set");
  AST_OVF: assert property (@(posedge clock) disable iff (!rst_b)
    (pushAct && sp_r == lim_r && sp_r >= UNDERFLOW_BOUND) |=> !stackErrTrap)
    else $error("push at limit trapped");
  AST_OVF_NEXT: assert property (@(posedge clock) disable iff (!rst_b)
    (spAccess && accAddr > lim_r) |=> stackErrTrap)
    else $error("overflow missed");
  AST_UNDF: assert property (@(posedge clock) disable iff (!rst_b)
    (spAccess && accAddr < UNDERFLOW_BOUND) |=> stackErrTrap)
    else $error("underflow missed");
  AST_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
    (stackErrTrap && !$past(overflow || underflow, 1)) |-> 1'b0)
    else $error("error without cause");
  AST_CALL_MSB: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == SPLC_IDLE && pushReq && !excPushReq) ##1 1'b1
    |=> memWe && memWdata[15:7] == 9'h000)
    else $error("call push high word not clear");
  AST_EXC_SRL: assert property (@(posedge clock) disable iff (!rst_b)
    (state_r == SPLC_IDLE && excPushReq) ##1 1'b1
    |=> memWdata[15:8] == $past(statusLowByte, 2))
    else $error("exception push lacks status byte");
  AST_PRIO: assert property (@(posedge clock) disable iff (!rst_b)
    (allTraps[0]) |=> trapValid && trapIdx == 3'h0)
    else $error("lowest vector not chosen");
endmodule : splc_stack_checker

// ---- verification/splc_core_model.sv ----
module splc_core_model
  import splc_pkg::*;
(
  input wire logic clock, // Core clock
  input wire logic memWe, // Stack write strobe
  input wire logic memRe, // Stack read strobe
  input wire logic [splc_pkg::DATA_W-1:0] memAddr, // Access address
  input wire logic [splc_pkg::DATA_W-1:0] memWdata, // Write data
  output logic [splc_pkg::DATA_W-1:0] memRdata // Read data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] mem [logic [DATA_W-1:0]];
  initial memRdata = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  // Data stands in the cycle after the read strobe, else it churns
  always @(posedge clock) begin
    if (memWe === 1'b1) mem[memAddr] = memWdata;
    if (memRe === 1'b1 && mem.exists(memAddr)) memRdata <= mem[memAddr];
    else memRdata <= ~memRdata;
  end
endmodule : splc_core_model

// ---- verification/splc_stack_checker_tb.sv ----
module splc_stack_checker_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import splc_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, pushReq = 1'b0, excPushReq = 1'b0;
  logic popReq = 1'b0, ptrAddrValid = 1'b0, limitWrite = 1'b0, spWrite = 1'b0;
  logic [PC_W-1:0] pcIn = '0;
  logic [STATUS_W-1:0] statusLowByte = 8'h00;
  logic [DATA_W-1:0] effectiveAddress = 16'h0000, limitData = 16'h0000;
  logic [DATA_W-1:0] spData = 16'h0000, memRdata, stackPointerReg;
  logic [DATA_W-1:0] stackLimitReg, memAddr, memWdata, popData;
  logic [NUM_SRC-1:0] trapReqs = 8'h00;
  logic memWe, memRe, popValid, stackErrTrap, trapValid;
  logic [SRC_W-1:0] trapIdx;
  logic [31:0] wrQ [$];
  logic [15:0] popQ [$];
  int nErr = 0, n_fail = 0, compares = 0;
  always #2 clock = ~clock;
  splc_stack_checker i_dut (.clock, .rst_b, .pushReq, .excPushReq, .popReq,
    .pcIn, .statusLowByte, .ptrAddrValid, .effectiveAddress, .limitWrite,
    .limitData, .spWrite, .spData, .memRdata, .trapReqs, .stackPointerReg,
    .stackLimitReg, .memWe, .memRe, .memAddr, .memWdata, .popData,
    .popValid, .stackErrTrap, .trapValid, .trapIdx);
  splc_core_model i_core (.clock, .memWe, .memRe, .memAddr, .memWdata,
    .memRdata);
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (memWe === 1'b1) wrQ.push_back({memAddr, memWdata});
    if (popValid === 1'b1) popQ.push_back(popData);
    if (stackErrTrap === 1'b1) nErr++;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Mismatches %0d, compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk16(input logic [15:0] got, exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16
  task automatic chkWr(input logic [15:0] a, d);
    logic [31:0] e;
    e = wrQ.size() > 0 ? wrQ.pop_front() : 32'hXXXXXXXX;
    chk16(e[31:16], a, "write address");
    chk16(e[15:0], d, "write data");
  endtask : chkWr
  task automatic chkPop(input logic [15:0] d);
    chk16(popQ.size() > 0 ? popQ.pop_front() : 16'hXXXX, d, "pop data");
  endtask : chkPop
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc
  task automatic doPush(input logic exc, input logic [22:0] pc,
                        input logic [7:0] sb);
    @(posedge clock);
    excPushReq <= exc;
    pushReq <= ~exc;
    pcIn <= pc;
    statusLowByte <= sb;
    @(posedge clock);
    excPushReq <= 1'b0;
    pushReq <= 1'b0;
    cyc(5);
  endtask : doPush
  task automatic doPop;
    @(posedge clock);
    popReq <= 1'b1;
    @(posedge clock);
    popReq <= 1'b0;
    cyc(7);
  endtask : doPop
  task automatic setLimit(input logic [15:0] v);
    @(posedge clock);
    limitWrite <= 1'b1;
    limitData <= v;
    @(posedge clock);
    limitWrite <= 1'b0;
    cyc(3);
  endtask : setLimit
  task automatic checkAddr(input logic [15:0] a);
    @(posedge clock);
    ptrAddrValid <= 1'b1;
    effectiveAddress <= a;
    @(posedge clock);
    ptrAddrValid <= 1'b0;
    cyc(3);
  endtask : checkAddr
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk16(stackPointerReg, SP_RESET, "reset pointer");
    chk16({13'h0000, memWe, memRe, stackErrTrap}, 16'h0000, "strobes");
    setLimit(16'h0805);
    chk16(stackLimitReg, 16'h0804, "limit bit0");
  endtask : t_reset
  task automatic t_push_pop;
    doPush(1'b0, 23'h7F1234, 8'hA5);
    chkWr(16'h0800, 16'h1234);
    chkWr(16'h0802, 16'h007F);
    chk16(stackPointerReg, 16'h0804, "pointer");
    chk16(16'(nErr), 16'h0000, "no trap up to limit");
    doPush(1'b1, 23'h055678, 8'hC3);
    chkWr(16'h0804, 16'h5678);
    chkWr(16'h0806, 16'hC305);
    chk16(16'(nErr), 16'h0001, "one trap past limit");
    setLimit(16'h0FFE);
    doPop;
    chkPop(16'hC305);
    chkPop(16'h5678);
    chk16(stackPointerReg, 16'h0804, "pointer after pop");
    doPop;
    chkPop(16'h007F);
    chkPop(16'h1234);
    chk16(stackPointerReg, 16'h0800, "pointer empty");
  endtask : t_push_pop
  task automatic t_under_ea;
    @(posedge clock);
    spWrite <= 1'b1;
    spData <= 16'h07FF;
    @(posedge clock);
    spWrite <= 1'b0;
    cyc(2);
    chk16(stackPointerReg, 16'h07FE, "pointer write");
    doPush(1'b0, 23'h000042, 8'h00);
    chkWr(16'h07FE, 16'h0042);
    chkWr(16'h0800, 16'h0000);
    chk16(16'(nErr), 16'h0002, "underflow trap");
    checkAddr(16'h0FFE);
    chk16(16'(nErr), 16'h0002, "address at limit");
    checkAddr(16'h1000);
    chk16(16'(nErr), 16'h0003, "address past limit");
  endtask : t_under_ea
  task automatic t_prio;
    logic [7:0] req [3] = '{8'hA4, 8'h80, 8'hFF};
    logic [2:0] win [3] = '{3'h2, 3'h7, 3'h0};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      trapReqs <= req[i];
      cyc(3);
      chk16({15'h0000, trapValid}, 16'h0001, "trap valid");
      chk16({13'h0000, trapIdx}, {13'h0000, win[i]}, "winner");
    end
    @(posedge clock);
    trapReqs <= 8'h00;
    cyc(3);
    chk16({15'h0000, trapValid}, 16'h0000, "no trap");
  endtask : t_prio
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(4);
    rst_b <= 1'b1;
    t_reset();
    t_push_pop();
    t_under_ea();
    t_prio();
    wrap_up();
  end
  initial begin
    #20000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : splc_stack_checker_tb
